//--- rtl/wsil_pkg.sv
package wsil_pkg;
    // Register addresses on the serial command port.
    localparam logic [4:0] ADDR_POWER_SETTING = 5'h07;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    // Field positions in power_setting_control.
    localparam int FRONTEND_BIT_POS = 6;
    localparam int RES_SELECT_POS = 5;
    localparam int RES_CODE_MSB = 4;
    // Field positions in wake_and_supply_status.
    localparam int ST_KEY_WAKE_POS = 2;
    localparam int ST_HOST_WAKE_POS = 1;
    localparam int ST_RAM_LOST_POS = 0;
    // Values after reset.
    localparam logic [7:0] POWER_SETTING_RESET = 8'h50;
    localparam logic [4:0] FIXED_RES_CODE = 5'h1F;
    // Debounce length in data clock periods.
    localparam int DEBOUNCE_PERIODS = 8195;
    // Operating modes.
    typedef enum logic [2:0] {
        WSIL_OFF = 3'h1,
        WSIL_WAKING = 3'h2,
        WSIL_ACTIVE = 3'h4
    } wsil_mode_t;
endpackage : wsil_pkg

//--- rtl/wsil_debounce.sv
`timescale 1ns/1ps
// Restartable debounce timer: any edge restarts or aborts the count.
module wsil_debounce #(
    parameter int PERIODS = wsil_pkg::DEBOUNCE_PERIODS
) (
    input wire logic clk_i, // Data clock.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic enable_i, // Debounce active (device awake).
    input wire logic pin_i, // Raw key wake level.
    output logic running_o, // Counter running.
    output logic done_o, // One-cycle pulse: level stable.
    output logic level_o // Debounced level.
);
    logic [13:0] count;
    logic pin_last;
    logic edge_seen;

    assign edge_seen = pin_i != pin_last;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_last <= 1'b1;
        end else begin
            pin_last <= pin_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || !enable_i) begin
            running_o <= 1'b0;
            count <= 14'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (edge_seen) begin
                // A second edge while counting aborts; otherwise start.
                running_o <= !running_o;
                count <= 14'h0000;
            end else if (running_o) begin
                if (count == 14'(PERIODS - 1)) begin
                    running_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count <= count + 14'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            level_o <= 1'b1;
        end else if (enable_i && running_o && !edge_seen
                && count == 14'(PERIODS - 1)) begin
            level_o <= pin_i;
        end else if (!enable_i) begin
            level_o <= pin_i;
        end
    end
endmodule : wsil_debounce

//--- rtl/wsil_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Select zero: fixed resistor in transmit, code in full duplex.
// - Five-bit resistor code, range 0 to 31, resets to 16.
// - Status flags readable at address 16 over the serial port.
// - Status read clears host-wake and RAM-lost flags and the interrupt.
// - Key-wake flag is the inverse of the debounced key pin.
// - While host-wake flag is one in ACTIVE, clock output enable is forced on.
// - A wake from OFF sets the RAM-supply-lost flag once supply and oscillator are ready.
// - Key pin falling in OFF wakes, sets flag, interrupts, enables clock.
// - Key pin high before wake interrupt keeps the device in OFF.
// - From ACTIVE only the off command enters OFF, never the wake pins.
// - In ACTIVE mode key edges start debounce; at 8195 update and interrupt.
// - A further edge before the limit stops debounce without update.
// - While debounce runs, clock output is forced on.
// - Key-wake interrupt cleared by status read or clear command.
// - Host pin rising in OFF wakes, sets flag, interrupts, enables clock.
// - Host pin low before wake interrupt keeps the device in OFF.
// - Active host pin rise sets flag; interrupt only on zero to one.
// - Supply loss sets RAM-lost flag; cleared once good and read.
module wsil_core #(
    parameter int DEBOUNCE_PERIODS = wsil_pkg::DEBOUNCE_PERIODS
) (
    input wire logic clk_i, // Data clock, 20 MHz.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic key_wake_pin_i, // Key wake pin, active low.
    input wire logic host_wake_pin_i, // Host wake pin, active high.
    input wire logic supply_good_i, // Digital supply above threshold.
    input wire logic osc_settled_i, // Crystal oscillator settled.
    input wire logic full_duplex_mode_i, // Full duplex mode active.
    input wire logic reg_wr_i, // Register write pulse.
    input wire logic reg_rd_i, // Register read pulse.
    input wire logic [4:0] reg_addr_i, // Register address.
    input wire logic [7:0] reg_wdata_i, // Write data.
    input wire logic off_cmd_i, // Off command pulse.
    input wire logic clear_irq_cmd_i, // Clear interrupt command pulse.
    input wire logic clk_on_ctrl_i, // Clock-on bit as written by host.
    output logic [7:0] reg_rdata_o, // Read data, valid after read.
    output logic supplies_on_o, // Internal supplies enabled.
    output logic irq_o, // Interrupt, active high.
    output logic clk_out_en_o, // Effective clock output enable.
    output logic [4:0] power_reduction_resistor_o, // Resistor code.
    output logic [7:0] power_setting_o // Power setting register image.
);
    wsil_pkg::wsil_mode_t mode;
    logic [7:0] power_setting_control;
    logic host_wake_flag;
    logic ram_supply_lost_flag;
    logic key_wake_flag;
    logic host_pin_last;
    logic key_pin_last;
    logic woke_by_key;
    logic deb_running;
    logic deb_done;
    logic deb_level;
    logic awake;
    logic wake_ready;
    logic status_read;
    logic host_rise;
    logic key_fall;
    logic wake_irq;

    assign awake = mode == wsil_pkg::WSIL_ACTIVE;
    assign wake_ready = supply_good_i && osc_settled_i;
    assign status_read = reg_rd_i && reg_addr_i == wsil_pkg::ADDR_STATUS;
    assign host_rise = host_wake_pin_i && !host_pin_last;
    assign key_fall = !key_wake_pin_i && key_pin_last;
    assign wake_irq = mode == wsil_pkg::WSIL_WAKING && wake_ready;

    wsil_debounce #(
        .PERIODS(DEBOUNCE_PERIODS)
    ) u_debounce (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .enable_i(awake),
        .pin_i(key_wake_pin_i),
        .running_o(deb_running),
        .done_o(deb_done),
        .level_o(deb_level)
    );

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            host_pin_last <= 1'b0;
            key_pin_last <= 1'b1;
        end else begin
            host_pin_last <= host_wake_pin_i;
            key_pin_last <= key_wake_pin_i;
        end
    end

    // Power mode sequence.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode <= wsil_pkg::WSIL_OFF;
            woke_by_key <= 1'b0;
        end else begin
            unique case (mode)
                wsil_pkg::WSIL_OFF: begin
                    if (key_fall) begin
                        mode <= wsil_pkg::WSIL_WAKING;
                        woke_by_key <= 1'b1;
                    end else if (host_rise) begin
                        mode <= wsil_pkg::WSIL_WAKING;
                        woke_by_key <= 1'b0;
                    end
                end
                wsil_pkg::WSIL_WAKING: begin
                    if (woke_by_key ? key_wake_pin_i : !host_wake_pin_i) begin
                        mode <= wsil_pkg::WSIL_OFF;
                    end else if (wake_ready) begin
                        mode <= wsil_pkg::WSIL_ACTIVE;
                    end
                end
                wsil_pkg::WSIL_ACTIVE: begin
                    // Pins never send the device off; the command
                    // needs host pin low and key pin released.
                    if (off_cmd_i && !host_wake_pin_i && key_wake_pin_i) begin
                        mode <= wsil_pkg::WSIL_OFF;
                    end
                end
                default: begin
                    mode <= wsil_pkg::WSIL_OFF;
                end
            endcase
        end
    end

    // Aborted wakes count as still off, so the check precedes the ready.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            host_wake_flag <= 1'b0;
        end else if (wake_irq && !woke_by_key && host_wake_pin_i) begin
            host_wake_flag <= 1'b1;
        end else if (awake && host_rise) begin
            host_wake_flag <= 1'b1;
        end else if (status_read) begin
            host_wake_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            key_wake_flag <= 1'b0;
        end else if (wake_irq && woke_by_key && !key_wake_pin_i) begin
            key_wake_flag <= 1'b1;
        end else if (deb_done) begin
            key_wake_flag <= !deb_level;
        end
    end

    // Supply loss and wake both set; set beats the read clear.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ram_supply_lost_flag <= 1'b1;
        end else if (!supply_good_i) begin
            ram_supply_lost_flag <= 1'b1;
        end else if (wake_irq) begin
            ram_supply_lost_flag <= 1'b1;
        end else if (status_read) begin
            ram_supply_lost_flag <= 1'b0;
        end
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else if ((wake_irq && (woke_by_key ? !key_wake_pin_i
                : host_wake_pin_i))
                || (awake && host_rise && !host_wake_flag)
                || deb_done) begin
            irq_o <= 1'b1;
        end else if (status_read || clear_irq_cmd_i) begin
            irq_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            power_setting_control <= wsil_pkg::POWER_SETTING_RESET;
        end else if (reg_wr_i && reg_addr_i == wsil_pkg::ADDR_POWER_SETTING)
                begin
            // Host keeps the frontend bit at one; stored as written.
            power_setting_control <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                wsil_pkg::ADDR_POWER_SETTING: begin
                    reg_rdata_o <= power_setting_control;
                end
                wsil_pkg::ADDR_STATUS: begin
                    reg_rdata_o <= 8'h00;
                    reg_rdata_o[wsil_pkg::ST_KEY_WAKE_POS] <= key_wake_flag;
                    reg_rdata_o[wsil_pkg::ST_HOST_WAKE_POS] <= host_wake_flag;
                    reg_rdata_o[wsil_pkg::ST_RAM_LOST_POS] <=
                        ram_supply_lost_flag;
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            supplies_on_o <= 1'b0;
        end else begin
            supplies_on_o <= mode != wsil_pkg::WSIL_OFF
                && !(mode == wsil_pkg::WSIL_ACTIVE && off_cmd_i
                && !host_wake_pin_i && key_wake_pin_i);
        end
    end

    // The host's clock-on bit is overridden while wake work is pending.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            clk_out_en_o <= 1'b0;
        end else begin
            clk_out_en_o <= awake && (clk_on_ctrl_i
                || host_wake_flag
                || deb_running
                || irq_o);
        end
    end

    // Transmit uses the fixed resistor unless select is set.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            power_reduction_resistor_o <= wsil_pkg::FIXED_RES_CODE;
        end else if (power_setting_control[wsil_pkg::RES_SELECT_POS]
                || full_duplex_mode_i) begin
            power_reduction_resistor_o <=
                power_setting_control[wsil_pkg::RES_CODE_MSB:0];
        end else begin
            power_reduction_resistor_o <= wsil_pkg::FIXED_RES_CODE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            power_setting_o <= wsil_pkg::POWER_SETTING_RESET;
        end else begin
            power_setting_o <= power_setting_control;
        end
    end
endmodule : wsil_core

//--- verification/wsil_core_assertions.sv
`timescale 1ns/1ps
module wsil_core_assertions (
    input wire logic clk_i, // Clock.
    input wire logic resetn_i, // Reset.
    input wire logic key_wake_pin_i, // Key pin.
    input wire logic supply_good_i, // Supply.
    input wire logic osc_settled_i, // Oscillator.
    input wire logic full_duplex_mode_i, // Duplex.
    input wire logic reg_wr_i, // Write.
    input wire logic reg_rd_i, // Read.
    input wire logic [4:0] reg_addr_i, // Address.
    input wire logic [7:0] reg_wdata_i, // Data.
    input wire logic off_cmd_i, // Off.
    input wire logic clear_irq_cmd_i, // Clear.
    input wire logic [7:0] reg_rdata_o, // Read data.
    input wire logic supplies_on_o, // Supplies.
    input wire logic irq_o, // Interrupt.
    input wire logic clk_out_en_o, // Clock out.
    input wire logic [4:0] power_reduction_resistor_o, // Code.
    input wire logic [7:0] power_setting_o // Register.
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    wire st_rd = reg_rd_i && reg_addr_i == wsil_pkg::ADDR_STATUS;
    wire sel = power_setting_o[wsil_pkg::RES_SELECT_POS];
    property p_irq_hold;
        $fell(irq_o) |-> $past(st_rd || clear_irq_cmd_i);
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped unasked");
    property p_rdata_hold;
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved");
    property p_off_only;
        irq_o && !off_cmd_i && !$past(off_cmd_i) |=> supplies_on_o;
    endproperty
    a_off_only: assert property (p_off_only)
        else $error("supplies dropped");
    property p_irq_supply;
        $rose(irq_o) |-> $past(supply_good_i && osc_settled_i);
    endproperty
    a_irq_supply: assert property (p_irq_supply)
        else $error("irq before supply");
    property p_key_clk;
        $changed(key_wake_pin_i) && supplies_on_o && supply_good_i &&
            osc_settled_i |-> ##[1:3] clk_out_en_o;
    endproperty
    a_key_clk: assert property (p_key_clk)
        else $error("clock not forced");
    // The code output lags the register by one cycle, like the image.
    property p_res_fixed;
        !sel && !$past(full_duplex_mode_i) |->
            power_reduction_resistor_o == wsil_pkg::FIXED_RES_CODE;
    endproperty
    a_res_fixed: assert property (p_res_fixed)
        else $error("fixed code wrong");
    property p_res_code;
        sel || $past(full_duplex_mode_i) |->
            power_reduction_resistor_o == power_setting_o[4:0];
    endproperty
    a_res_code: assert property (p_res_code)
        else $error("programmed code wrong");
    property p_wr;
        reg_wr_i && reg_addr_i == wsil_pkg::ADDR_POWER_SETTING |=> ##1
            power_setting_o == $past(reg_wdata_i, 2);
    endproperty
    a_wr: assert property (p_wr)
        else $error("write lost");
    c_irq: cover property ($rose(irq_o));
    c_key: cover property ($changed(key_wake_pin_i) && supplies_on_o);
    c_off: cover property ($fell(supplies_on_o));
endmodule : wsil_core_assertions

bind wsil_core wsil_core_assertions u_wsil_core_assertions (
    .clk_i(clk_i), .resetn_i(resetn_i), .key_wake_pin_i(key_wake_pin_i),
    .supply_good_i(supply_good_i), .osc_settled_i(osc_settled_i),
    .full_duplex_mode_i(full_duplex_mode_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .off_cmd_i(off_cmd_i),
    .clear_irq_cmd_i(clear_irq_cmd_i), .reg_rdata_o(reg_rdata_o),
    .supplies_on_o(supplies_on_o), .irq_o(irq_o),
    .clk_out_en_o(clk_out_en_o),
    .power_reduction_resistor_o(power_reduction_resistor_o),
    .power_setting_o(power_setting_o)
);

//--- verification/wsil_supply_model.sv
`timescale 1ns/1ps
// Supply monitor and crystal; delay_i makes settling prompt or slow.
module wsil_supply_model (
    input wire logic clk_i, // Data clock.
    input wire logic supplies_on_i, // Supplies requested.
    input wire logic drop_i, // Pull the supply below threshold.
    input wire logic [7:0] delay_i, // Settling cycles.
    output logic supply_good_o, // Supply good.
    output logic osc_settled_o // Oscillator settled.
);
    logic [7:0] count;
    always_ff @(posedge clk_i) begin
        if (!supplies_on_i) begin
            count <= 8'h00;
        end else if (count != 8'hFF) begin
            count <= count + 8'h01;
        end
    end
    // The crystal settles one cycle after the supply, as on real parts.
    assign supply_good_o = supplies_on_i && !drop_i && count >= delay_i;
    assign osc_settled_o = supplies_on_i && count > delay_i;
endmodule : wsil_supply_model

//--- verification/wakeup_status_irq_logic_tb_top.sv
`timescale 1ns/1ps
module wakeup_status_irq_logic_tb_top;
    localparam int DEB = 20;
    localparam logic [4:0] ST = wsil_pkg::ADDR_STATUS;
    logic clk_i, resetn_i, key, host, sgood, osc, fd, wr, rd, offc, clrc;
    logic son, irq, cen, drop;
    logic [4:0] addr, res;
    logic [7:0] wdata, rdata, pset, dly;
    int fails = 0;
    int tests_run = 0;
    wsil_core #(.DEBOUNCE_PERIODS(DEB)) u_wsil_core (
        .clk_i(clk_i), .resetn_i(resetn_i), .key_wake_pin_i(key),
        .host_wake_pin_i(host), .supply_good_i(sgood), .osc_settled_i(osc),
        .full_duplex_mode_i(fd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .off_cmd_i(offc),
        .clear_irq_cmd_i(clrc), .clk_on_ctrl_i(1'b0), .reg_rdata_o(rdata),
        .supplies_on_o(son), .irq_o(irq), .clk_out_en_o(cen),
        .power_reduction_resistor_o(res), .power_setting_o(pset));
    wsil_supply_model u_wsil_supply_model (.clk_i(clk_i),
        .supplies_on_i(son), .drop_i(drop), .delay_i(dly),
        .supply_good_o(sgood), .osc_settled_o(osc));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
        check(rdata, exp);
    endtask : rd_chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic wait_irq(input int lim, input logic exp);
        for (int i = 0; i < lim && irq !== 1'b1; i++) tick(1);
        check({7'h00, irq}, {7'h00, exp});
    endtask : wait_irq
    task automatic t_reset;
        rd_chk(wsil_pkg::ADDR_POWER_SETTING, wsil_pkg::POWER_SETTING_RESET);
        check({3'h0, res}, {3'h0, wsil_pkg::FIXED_RES_CODE});
        rd_chk(ST, 8'h01);
        rd_chk(ST, 8'h01);
        $display("test reset end");
    endtask : t_reset
    task automatic t_host_wake;
        host = 1'b1;
        wait_irq(50, 1'b1);
        tick(1);
        check({7'h00, cen}, 8'h01);
        rd_chk(ST, 8'h03);
        check({7'h00, irq}, 8'h00);
        rd_chk(ST, 8'h00);
        tick(2);
        check({7'h00, cen}, 8'h00);
        $display("test host wake end");
    endtask : t_host_wake
    task automatic t_power;
        logic [6:0] tab [4] = '{7'h20, 7'h05, 7'h45, 7'h70};
        foreach (tab[i]) begin
            fd = tab[i][6];
            wr_reg(wsil_pkg::ADDR_POWER_SETTING, {2'h1, tab[i][5:0]});
            tick(2);
            rd_chk(wsil_pkg::ADDR_POWER_SETTING, {2'h1, tab[i][5:0]});
            check(pset, {2'h1, tab[i][5:0]});
            check({3'h0, res}, (tab[i][5] || fd) ? {3'h0, tab[i][4:0]} :
                {3'h0, wsil_pkg::FIXED_RES_CODE});
        end
        fd = 1'b0;
        $display("test power end");
    endtask : t_power
    task automatic t_host_active;
        host = 1'b0;
        tick(3);
        check({7'h00, son}, 8'h01);
        host = 1'b1;
        wait_irq(20, 1'b1);
        pulse(clrc);
        tick(1);
        check({7'h00, irq}, 8'h00);
        host = 1'b0;
        tick(2);
        host = 1'b1;
        tick(10);
        check({7'h00, irq}, 8'h00);
        rd_chk(ST, 8'h02);
        host = 1'b0;
        $display("test host active end");
    endtask : t_host_active
    task automatic t_key;
        key = 1'b0;
        tick(DEB - 4);
        check({6'h00, cen, irq}, 8'h02);
        wait_irq(10, 1'b1);
        rd_chk(ST, 8'h04);
        key = 1'b1;
        tick(3);
        key = 1'b0;
        tick(3 * DEB);
        check({7'h00, irq}, 8'h00);
        key = 1'b1;
        wait_irq(DEB + 8, 1'b1);
        rd_chk(ST, 8'h00);
        $display("test key end");
    endtask : t_key
    task automatic t_supply;
        drop = 1'b1;
        tick(3);
        rd_chk(ST, 8'h01);
        drop = 1'b0;
        tick(3);
        rd_chk(ST, 8'h01);
        rd_chk(ST, 8'h00);
        $display("test supply end");
    endtask : t_supply
    task automatic t_off;
        pulse(offc);
        tick(3);
        check({7'h00, son}, 8'h00);
        dly = 8'h28;
        key = 1'b0;
        tick(5);
        key = 1'b1;
        tick(60);
        check({6'h00, son, irq}, 8'h00);
        dly = 8'h03;
        key = 1'b0;
        wait_irq(50, 1'b1);
        rd_chk(ST, 8'h05);
        $display("test off end");
    endtask : t_off
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
    initial begin
        {resetn_i, host, fd, wr, rd, offc, clrc, drop} = 8'h00;
        key = 1'b1;
        addr = 5'h00;
        wdata = 8'h00;
        dly = 8'h05;
        tick(3);
        resetn_i = 1'b1;
        t_reset();
        t_host_wake();
        t_power();
        t_host_active();
        t_key();
        t_supply();
        t_off();
        print_verdict();
    end
endmodule : wakeup_status_irq_logic_tb_top
